// file: bench/psl_led_rx.sv
// far side model: two indicator lamps and a serial shift receiver
// assumes pin levels change on ref_clk; a floating lamp pin reads high
`timescale 1ns/1ns
`default_nettype none

module psl_led_rx
(
  input  wire logic   ref_clk,
  input  wire logic   zero_out,
  input  wire logic   zero_oe_n,
  input  wire logic   one_out,
  input  wire logic   one_oe_n,
  output logic [11:0] frame_reg,
  output logic        frame_done
);
  logic [11:0] shift_reg = 12'h000;
  logic [3:0]  idx_reg = 4'h0;
  logic [3:0]  low_reg = 4'h0;
  logic        prev_reg = 1'b1;
  logic [3:0]  idx_next;
  wire         data_w = zero_oe_n ? 1'b1 : zero_out;
  wire         sclk_w = one_oe_n ? 1'b1 : one_out;

  // long low run marks frame start
  assign idx_next = (low_reg >= 4'h5) ? 4'h0 : idx_reg;

  initial frame_done = 1'b0;
  initial frame_reg = 12'h000;

  // data taken on rising serial clock
  always @(posedge ref_clk)
  begin
    prev_reg <= sclk_w;
    frame_done <= 1'b0;
    low_reg <= sclk_w ? 4'h0 : ((low_reg == 4'hf) ? low_reg : low_reg + 4'h1);
    if (sclk_w && !prev_reg)
    begin
      shift_reg <= {shift_reg[10:0], data_w};
      idx_reg <= idx_next + 4'h1;
      if (idx_next == 4'hb)
      begin
        frame_reg <= {shift_reg[10:0], data_w};
        frame_done <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// file: bench/psl_led_top_bench.sv
// self-checking bench of the status indicator driver
// assumes short ms ticks (MS_CYCLES 10) and the lamp model beside it
`timescale 1ns/1ns
`default_nettype none

module psl_led_top_bench;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        link_up = 1'b0;
  logic [1:0]  link_speed = 2'b00;
  logic        full_duplex = 1'b0;
  logic        tx_activity = 1'b0;
  logic        rx_activity = 1'b0;
  logic        collision = 1'b0;
  logic        aneg_fault = 1'b0;
  logic        z_out;
  logic        z_oe_n;
  logic        o_out;
  logic        o_oe_n;
  logic [11:0] frame_reg;
  logic        frame_done;
  int          fail_count = 0;
  int          n_checks = 0;
  wire [1:0]   pin0 = {z_out, z_oe_n};
  wire [1:0]   pin1 = {o_out, o_oe_n};

  always #20 ref_clk = ~ref_clk;

  psl_led_top #(.MS_CYCLES(10), .PORT_NUM(0)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link_up(link_up),
    .link_speed(link_speed), .full_duplex(full_duplex), .tx_activity(tx_activity),
    .rx_activity(rx_activity), .collision(collision), .aneg_fault(aneg_fault),
    .indicator_pin_zero_out(z_out), .indicator_pin_zero_oe_n(z_oe_n),
    .indicator_pin_one_out(o_out), .indicator_pin_one_oe_n(o_oe_n));

  psl_led_rx u_rx (.ref_clk(ref_clk), .zero_out(z_out), .zero_oe_n(z_oe_n), .one_out(o_out),
    .one_oe_n(o_oe_n), .frame_reg(frame_reg), .frame_done(frame_done));

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  // one request at a time, held until waitrequest is seen low
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(posedge ref_clk);
  endtask

  // counts level changes on both pins over a span of cycles
  task automatic edges(input int span, output int t0, output int t1);
    logic [1:0] p0;
    logic [1:0] p1;
    p0 = pin0;
    p1 = pin1;
    t0 = 0;
    t1 = 0;
    repeat (span)
    begin
      @(posedge ref_clk);
      if (pin0 !== p0) t0++;
      if (pin1 !== p1) t1++;
      p0 = pin0;
      p1 = pin1;
    end
  endtask

  function automatic logic [1:0] pexp(input logic lit, input logic pol, input logic tri_en);
    return {~(lit ^ pol), ~lit & tri_en};
  endfunction

  function automatic logic lit_of(input logic [3:0] m);
    case (m)
      4'h0: return link_up;
      4'h1: return link_up && link_speed == 2'b10;
      4'h2: return link_up && link_speed == 2'b01;
      4'h3: return link_up && link_speed == 2'b00;
      4'h4: return link_up && link_speed != 2'b00;
      4'h5: return link_up && link_speed != 2'b01;
      4'h6: return link_up && link_speed != 2'b10;
      4'h8: return link_up && full_duplex;
      4'hc: return aneg_fault;
      4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic t_regs();
    logic [31:0] d;
    bus_rd(4'h0, d);
    chk_reg("mode reset", 32'ha0, d);
    bus_rd(4'h4, d);
    chk_reg("behaviour reset", 32'h211, d);
    bus_rd(4'h8, d);
    chk_reg("drive reset", 32'h200, d);
    bus_rd(4'h2, d);
    chk_reg("unmapped read", 32'h0, d);
  endtask

  task automatic t_boot();
    int t0;
    int t1;
    bus_wr(4'h0, 32'hf0, 4'hf);
    settle();
    edges(9000, t0, t1);
    chk_reg("boot toggles", 32'd4, t0);
    chk_reg("forced pin changes", 32'd0, t1);
    chk_pin("forced pin", 2'b00, pin1);
    repeat (2000) @(posedge ref_clk);
    chk_pin("pin after boot", 2'b11, pin0);
  endtask

  task automatic t_modes();
    for (int m = 0; m < 16; m++)
    begin
      if (m == 13) continue;
      for (int s = 0; s < 3; s++)
      begin
        for (int l = 0; l < 2; l++)
        begin
          @(posedge ref_clk);
          link_up <= l[0];
          link_speed <= s[1:0];
          full_duplex <= s[0];
          aneg_fault <= l[0];
          bus_wr(4'h0, {24'h0, (l == 1) ? 4'hc : 4'hd, m[3:0]}, 4'hf);
          settle();
          chk_pin("pin zero mode", pexp(lit_of(m[3:0]), 1'b0, 1'b1), pin0);
          if (l == 1)
            chk_pin("fault on pin one", pexp(1'b1, 1'b0, 1'b1), pin1);
          else
            chk_pin("serial code on pin one", 2'b11, pin1);
        end
      end
    end
  endtask

  task automatic t_drive();
    logic [31:0] d;
    bus_wr(4'h0, 32'hef, 4'hf);
    bus_wr(4'h8, 32'h400, 4'hf);
    settle();
    chk_pin("active high lit", pexp(1'b1, 1'b1, 1'b0), pin0);
    chk_pin("inactive driven", pexp(1'b0, 1'b0, 1'b0), pin1);
    bus_wr(4'h8, 32'h0, 4'h1);
    bus_rd(4'h8, d);
    chk_reg("drive lanes", 32'h400, d);
    bus_wr(4'h8, 32'h200, 4'hf);
  endtask

  task automatic t_shape();
    int t0;
    int t1;
    @(posedge ref_clk);
    rx_activity <= 1'b1;
    // pin zero blinks fastest rate, pin one has shaping off
    bus_wr(4'h4, 32'h00d, 4'hf);
    bus_wr(4'h0, 32'haa, 4'hf);
    settle();
    edges(750, t0, t1);
    chk_reg("fast blink toggles", 32'd3, t0);
    chk_reg("unshaped pin changes", 32'd0, t1);
    chk_pin("unshaped pin", 2'b11, pin1);
    bus_wr(4'h4, 32'h10d, 4'hf);
    settle();
    edges(600, t0, t1);
    chk_reg("receive ignored", 32'd0, t0);
    chk_pin("receive ignored pin", 2'b11, pin0);
    @(posedge ref_clk);
    tx_activity <= 1'b1;
    edges(600, t0, t1);
    chk_reg("transmit blinks", 32'd1, 32'(t0 >= 2));
    @(posedge ref_clk);
    tx_activity <= 1'b0;
    rx_activity <= 1'b0;
  endtask

  task automatic t_serial();
    @(posedge ref_clk);
    link_up <= 1'b1;
    link_speed <= 2'b10;
    full_duplex <= 1'b1;
    aneg_fault <= 1'b0;
    // both polarity bits high; serial stream levels bypass polarity and equal logical states
    bus_wr(4'h8, 32'he00, 4'hf);
    bus_wr(4'h0, 32'h0d, 4'hf);
    repeat (2) @(posedge frame_done);
    chk_reg("serial frame", 32'hc40, {20'h0, frame_reg});
    chk_pin("serial pins driven", 2'b00, {z_oe_n, o_oe_n});
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_boot();
    t_modes();
    t_drive();
    t_shape();
    t_serial();
    summarize();
  end
endmodule

`default_nettype wire

// file: inc/psl_defs.svh
// constants of the status indicator driver: offsets, fields, resets, times
// assumes a single 25 MHz core clock; times in ms become ms ticks
`ifndef PSL_DEFS_SVH
`define PSL_DEFS_SVH

`define PSL_CLK_NS          40
`define PSL_MS_NS           1000000
`define PSL_MS_CYCLES       (`PSL_MS_NS / `PSL_CLK_NS)
`define PSL_BOOT_MS         10'd1000
`define PSL_BOOT_HALF_MS    10'd200
`define PSL_BLINK_HALF_R0   9'd200
`define PSL_BLINK_HALF_R1   9'd100
`define PSL_BLINK_HALF_R2   9'd50
`define PSL_BLINK_HALF_R3   9'd25
`define PSL_STRETCH_R0      9'd50
`define PSL_STRETCH_R1      9'd100
`define PSL_STRETCH_R2      9'd200
`define PSL_STRETCH_R3      9'd400
`define PSL_SER_HALF_CYC    4'd4
`define PSL_SER_BITS        4'd12

`define PSL_OFS_MODE        4'h0
`define PSL_OFS_BEHAV       4'h4
`define PSL_OFS_DRIVE       4'h8
`define PSL_OFS_STATUS      4'hc

`define PSL_MODE_P0_LSB     0
`define PSL_MODE_P1_LSB     4
`define PSL_BEH_P0_LSB      0
`define PSL_BEH_P1_LSB      4
`define PSL_BEH_TXONLY_BIT  8
`define PSL_BEH_BOOT_BIT    9
`define PSL_DRV_TRI_BIT     9
`define PSL_DRV_POL_LSB     10

`define PSL_MODE_RST        8'ha0
`define PSL_BEHAV_RST       10'h211
`define PSL_POL_RST         4'h0
`define PSL_TRI_RST         1'b1

`endif

// file: inc/psl_pkg.sv
// types shared by the status indicator driver
// assumes psl_defs.svh supplies the numeric constants
package psl_pkg;

  typedef enum logic [3:0] {
    PSL_M_LINK      = 4'h0,
    PSL_M_L1000     = 4'h1,
    PSL_M_L100      = 4'h2,
    PSL_M_L10       = 4'h3,
    PSL_M_L100_1000 = 4'h4,
    PSL_M_L10_1000  = 4'h5,
    PSL_M_L10_100   = 4'h6,
    PSL_M_RSV7      = 4'h7,
    PSL_M_DUPLEX    = 4'h8,
    PSL_M_COLL      = 4'h9,
    PSL_M_ACT       = 4'ha,
    PSL_M_RSV11     = 4'hb,
    PSL_M_ANFAULT   = 4'hc,
    PSL_M_SERIAL    = 4'hd,
    PSL_M_OFF       = 4'he,
    PSL_M_ON        = 4'hf
  } psl_mode_t;

  typedef enum logic [1:0] {
    PSL_SPD_10   = 2'b00,
    PSL_SPD_100  = 2'b01,
    PSL_SPD_1000 = 2'b10
  } psl_speed_t;

  typedef enum logic [1:0] {
    PSL_SER_LOAD = 2'b00,
    PSL_SER_LOW  = 2'b01,
    PSL_SER_HIGH = 2'b10
  } psl_ser_st_t;

endpackage

// file: rtl/psl_fx.sv
// blink / pulse-stretch shaper for one indicator channel
// assumes a one-cycle ms_tick enable from the top's divider
`include "psl_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module psl_fx
  import psl_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       ms_tick,
  input  wire logic       ev,
  input  wire logic       en,
  input  wire logic       stretch,
  input  wire logic [1:0] rate,
  output logic            mod_reg
);

  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic       phase_reg;
  logic       phase_next;
  logic       mod_next;

  function automatic logic [8:0] blink_half(input logic [1:0] r);
    unique case (r)
      2'd0: blink_half = `PSL_BLINK_HALF_R0;
      2'd1: blink_half = `PSL_BLINK_HALF_R1;
      2'd2: blink_half = `PSL_BLINK_HALF_R2;
      2'd3: blink_half = `PSL_BLINK_HALF_R3;
    endcase
  endfunction

  function automatic logic [8:0] stretch_len(input logic [1:0] r);
    unique case (r)
      2'd0: stretch_len = `PSL_STRETCH_R0;
      2'd1: stretch_len = `PSL_STRETCH_R1;
      2'd2: stretch_len = `PSL_STRETCH_R2;
      2'd3: stretch_len = `PSL_STRETCH_R3;
    endcase
  endfunction

  wire [8:0] half_ms = blink_half(rate);
  wire [8:0] hold_ms = stretch_len(rate);

  always_comb
  begin
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    if (stretch)
    begin
      phase_next = 1'b0;
      if (ev)
        cnt_next = hold_ms;
      else if (ms_tick && cnt_reg != 9'd0)
        cnt_next = cnt_reg - 9'd1;
    end
    else if (!ev)
    begin
      cnt_next   = 9'd0;
      phase_next = 1'b0;
    end
    else if (ms_tick)
    begin
      if (cnt_reg >= half_ms - 9'd1)
      begin
        cnt_next   = 9'd0;
        phase_next = ~phase_reg;
      end
      else
        cnt_next = cnt_reg + 9'd1;
    end
  end

  assign mod_next = en & (stretch ? (ev | (cnt_reg != 9'd0)) : (ev & phase_reg));

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg   <= 9'd0;
      phase_reg <= 1'b0;
      mod_reg   <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      mod_reg   <= mod_next;
    end
  end

  stretch_load_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (stretch && ev) |=> (cnt_reg == $past(hold_ms)))
    else $error("stretch length not loaded");

  blink_half_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!stretch && ev && $stable(rate)) |-> (cnt_reg < `PSL_BLINK_HALF_R0))
    else $error("blink half period overrun");

  no_shape_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!en) |=> !mod_reg)
    else $error("shaping while disabled");

endmodule
`default_nettype wire

// file: rtl/psl_led_top.sv
// status indicator driver: two pins, direct or serial, with avalon registers
// assumes phy status inputs come from logic on ref_clk
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`include "psl_defs.svh"
`timescale 1ns/1ns
`default_nettype none

// Function
// - two pins, mode, behaviour and polarity configured per pin; one drive state for both
// - four-bit polarity field, active low default
// - inactive pin tristated or driven to its unlit level (high when active low)
// - per-pin mode field, values 0 to 15
// - blink/stretch only as behaviour settings say
// - mode 0: link any speed, activity
// - modes 1-3: link at single speed
// - modes 4-6: link on speed pair
// - mode 8: full duplex, half-duplex collisions
// - mode 9: collision events only
// - mode 10: activity, optionally transmit only
// - mode 12: auto-negotiation fault shown
// - mode 13 serial, port 0 only
// - mode 14 force off, 15 on
// - force-on suppresses post-reset blink
// - serial stream of every status bit
// - pin0 data, pin1 clock, rising edge
// - blink and stretch rates selectable
module psl_led_top
  import psl_pkg::*;
#(
  parameter int          MS_CYCLES = `PSL_MS_CYCLES,
  parameter int          PORT_NUM  = 0
)
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        link_up,
  input  wire logic [1:0]  link_speed,
  input  wire logic        full_duplex,
  input  wire logic        tx_activity,
  input  wire logic        rx_activity,
  input  wire logic        collision,
  input  wire logic        aneg_fault,
  output logic             indicator_pin_zero_out,
  output logic             indicator_pin_zero_oe_n,
  output logic             indicator_pin_one_out,
  output logic             indicator_pin_one_oe_n
);

  localparam int NCH = 14;

  logic [7:0]  mode_reg;
  logic [9:0]  behav_reg;
  logic [3:0]  pol_reg;
  logic        tri_reg;
  logic [15:0] ms_cnt_reg;
  logic        ms_tick_reg;
  logic [9:0]  boot_cnt_reg;
  logic [1:0]  lit_reg;
  logic [1:0]  lit_next;
  logic [11:0] frame_reg;
  logic [3:0]  bit_idx_reg;
  logic [3:0]  ser_cnt_reg;
  logic        serial_indicator_out_reg;
  logic        serial_indicator_shift_clk_reg;
  psl_ser_st_t ser_st_reg;
  psl_ser_st_t ser_st_next;
  logic [NCH-1:0] ch_lit;
  logic [NCH-1:0] ch_mod;

  // register bus decode
  wire        req      = avs_read | avs_write;
  wire        accept   = req & ~avs_waitrequest;
  wire        wr_mode  = accept & avs_write & (avs_address == `PSL_OFS_MODE);
  wire        wr_behav = accept & avs_write & (avs_address == `PSL_OFS_BEHAV);
  wire        wr_drive = accept & avs_write & (avs_address == `PSL_OFS_DRIVE);
  wire [31:0] lane_m   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                          {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] drive_w  = {18'h0, pol_reg, tri_reg, 9'h0};
  wire [31:0] mode_m   = ({24'h0, mode_reg} & ~lane_m) | (avs_writedata & lane_m);
  wire [31:0] behav_m  = ({22'h0, behav_reg} & ~lane_m) | (avs_writedata & lane_m);
  wire [31:0] drive_m  = (drive_w & ~lane_m) | (avs_writedata & lane_m);

  wire [3:0]  mode0    = mode_reg[`PSL_MODE_P0_LSB +: 4];
  wire [3:0]  mode1    = mode_reg[`PSL_MODE_P1_LSB +: 4];
  wire [3:0]  beh0     = behav_reg[`PSL_BEH_P0_LSB +: 4];
  wire [3:0]  beh1     = behav_reg[`PSL_BEH_P1_LSB +: 4];
  wire        act_sel  = behav_reg[`PSL_BEH_TXONLY_BIT] ? tx_activity : (tx_activity | rx_activity);
  wire        ser_on   = (mode0 == PSL_M_SERIAL) && (PORT_NUM == 0);
  wire        boot_on  = behav_reg[`PSL_BEH_BOOT_BIT] && (boot_cnt_reg != 10'd0);
  // boot phase flips every half window: odd quotient lit
  wire [9:0]  boot_q   = boot_cnt_reg / `PSL_BOOT_HALF_MS;
  wire        boot_ph  = boot_q[0];
  wire        ms_wrap  = (ms_cnt_reg == 16'(MS_CYCLES - 1));
  wire        ser_turn = (ser_cnt_reg == `PSL_SER_HALF_CYC - 4'd1);
  wire [31:0] status_w = {20'h0, boot_on, ser_on, lit_reg, aneg_fault, collision,
                          rx_activity, tx_activity, full_duplex, link_speed, link_up};
  wire [31:0] rd_sel   = (avs_address == `PSL_OFS_MODE)   ? {24'h0, mode_reg} :
                         (avs_address == `PSL_OFS_BEHAV)  ? {22'h0, behav_reg} :
                         (avs_address == `PSL_OFS_DRIVE)  ? drive_w :
                         (avs_address == `PSL_OFS_STATUS) ? status_w : 32'h0;

  // per-mode decode
  // returns {event_only, base, event}
  function automatic logic [2:0] decode(input logic [3:0] m, input logic act);
    logic s10;
    logic s100;
    logic s1000;
    s10   = link_up && (link_speed == PSL_SPD_10);
    s100  = link_up && (link_speed == PSL_SPD_100);
    s1000 = link_up && (link_speed == PSL_SPD_1000);
    unique case (m)
      PSL_M_LINK:      decode = {1'b0, link_up, link_up & act};
      PSL_M_L1000:     decode = {1'b0, s1000, s1000 & act};
      PSL_M_L100:      decode = {1'b0, s100, s100 & act};
      PSL_M_L10:       decode = {1'b0, s10, s10 & act};
      PSL_M_L100_1000: decode = {1'b0, s100 | s1000, (s100 | s1000) & act};
      PSL_M_L10_1000:  decode = {1'b0, s10 | s1000, (s10 | s1000) & act};
      PSL_M_L10_100:   decode = {1'b0, s10 | s100, (s10 | s100) & act};
      PSL_M_DUPLEX:    decode = {1'b1, link_up & full_duplex, link_up & ~full_duplex & collision};
      PSL_M_COLL:      decode = {1'b1, 1'b0, collision};
      PSL_M_ACT:       decode = {1'b1, 1'b0, act};
      PSL_M_ANFAULT:   decode = {1'b0, aneg_fault, 1'b0};
      PSL_M_ON:        decode = 3'b010;
      default:         decode = 3'b000;
    endcase
  endfunction

  // serial bit order: link modes, reserved, duplex, coll, act, reserved, tx, rx, fault
  function automatic logic [3:0] ser_mode(input int i);
    unique case (i)
      0, 1, 2, 3: ser_mode = 4'(i);
      5:          ser_mode = PSL_M_DUPLEX;
      6:          ser_mode = PSL_M_COLL;
      7, 9, 10:   ser_mode = PSL_M_ACT;
      11:         ser_mode = PSL_M_ANFAULT;
      default:    ser_mode = PSL_M_RSV7;
    endcase
  endfunction

  // channels 0,1 are the pins; 2..13 the serial stream bits, shaped by pin 0 settings
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1)
    begin : g_ch
      wire [3:0] m   = (c == 0) ? mode0 : (c == 1) ? mode1 : ser_mode(c - 2);
      wire       a   = (c == 11) ? tx_activity : (c == 12) ? rx_activity : act_sel;
      wire [3:0] b   = (c == 1) ? beh1 : beh0;
      wire [2:0] d   = decode(m, a);
      assign ch_lit[c] = (d[1] & ~ch_mod[c]) | (d[2] & ch_mod[c]);
      psl_fx u_fx (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ms_tick (ms_tick_reg),
        .ev      (d[0]),
        .en      (b[0]),
        .stretch (b[1]),
        .rate    (b[3:2]),
        .mod_reg (ch_mod[c])
      );
    end
  endgenerate

  // independent pins, boot skipped when forced on
  assign lit_next[0] = (boot_on && mode0 != PSL_M_ON) ? boot_ph : ch_lit[0];
  assign lit_next[1] = (boot_on && mode1 != PSL_M_ON) ? boot_ph : ch_lit[1];

  // polarity after logic state, drive state last
  wire pin0_lvl = ser_on ? serial_indicator_out_reg : (lit_next[0] ~^ pol_reg[0]);
  wire pin1_lvl = ser_on ? serial_indicator_shift_clk_reg : (lit_next[1] ~^ pol_reg[1]);
  // inactive pins float when tristate selected
  wire pin0_oen = ~ser_on & ~lit_next[0] & tri_reg;
  wire pin1_oen = ~ser_on & ~lit_next[1] & tri_reg;

  // data changes with clock low, held across rise
  always_comb
  begin
    unique case (ser_st_reg)
      PSL_SER_LOAD: ser_st_next = PSL_SER_LOW;
      PSL_SER_LOW:  ser_st_next = ser_turn ? PSL_SER_HIGH : PSL_SER_LOW;
      PSL_SER_HIGH: ser_st_next = !ser_turn ? PSL_SER_HIGH :
                                  (bit_idx_reg == `PSL_SER_BITS - 4'd1) ? PSL_SER_LOAD : PSL_SER_LOW;
      default:      ser_st_next = PSL_SER_LOAD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      mode_reg        <= `PSL_MODE_RST;
      behav_reg       <= `PSL_BEHAV_RST;
      pol_reg         <= `PSL_POL_RST;
      tri_reg         <= `PSL_TRI_RST;
    end
    else
    begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest)
        avs_readdata <= avs_read ? rd_sel : 32'h0;
      if (wr_mode)
        mode_reg <= mode_m[7:0];
      if (wr_behav)
        behav_reg <= behav_m[9:0];
      if (wr_drive)
      begin
        pol_reg <= drive_m[`PSL_DRV_POL_LSB +: 4];
        tri_reg <= drive_m[`PSL_DRV_TRI_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ms_cnt_reg   <= 16'h0;
      ms_tick_reg  <= 1'b0;
      boot_cnt_reg <= `PSL_BOOT_MS;
    end
    else
    begin
      ms_cnt_reg  <= ms_wrap ? 16'h0 : ms_cnt_reg + 16'h1;
      ms_tick_reg <= ms_wrap;
      if (ms_tick_reg && boot_cnt_reg != 10'd0)
        boot_cnt_reg <= boot_cnt_reg - 10'd1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ser_st_reg                     <= PSL_SER_LOAD;
      ser_cnt_reg                    <= 4'h0;
      bit_idx_reg                    <= 4'h0;
      frame_reg                      <= 12'h0;
      serial_indicator_out_reg       <= 1'b0;
      serial_indicator_shift_clk_reg <= 1'b0;
    end
    else
    begin
      ser_st_reg  <= ser_st_next;
      ser_cnt_reg <= (ser_st_reg == PSL_SER_LOAD || ser_turn) ? 4'h0 : ser_cnt_reg + 4'h1;
      serial_indicator_shift_clk_reg <= (ser_st_next == PSL_SER_HIGH);
      if (ser_st_reg == PSL_SER_LOAD)
      begin
        frame_reg                <= ch_lit[NCH-1:2];
        bit_idx_reg              <= 4'h0;
        serial_indicator_out_reg <= ch_lit[2];
      end
      else if (ser_st_reg == PSL_SER_HIGH && ser_st_next == PSL_SER_LOW)
      begin
        bit_idx_reg              <= bit_idx_reg + 4'h1;
        serial_indicator_out_reg <= frame_reg[bit_idx_reg + 4'h1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lit_reg                 <= 2'b00;
      indicator_pin_zero_out  <= 1'b1;
      indicator_pin_zero_oe_n <= 1'b1;
      indicator_pin_one_out   <= 1'b1;
      indicator_pin_one_oe_n  <= 1'b1;
    end
    else
    begin
      lit_reg                 <= lit_next;
      indicator_pin_zero_out  <= pin0_lvl;
      indicator_pin_zero_oe_n <= pin0_oen;
      indicator_pin_one_out   <= pin1_lvl;
      indicator_pin_one_oe_n  <= pin1_oen;
    end
  end

  force_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode0 == PSL_M_OFF && !boot_on) |=> !lit_reg[0])
    else $error("force off pin lit");

  force_on_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode1 == PSL_M_ON) |=> lit_reg[1])
    else $error("force on pin dark or blinking");

  polarity_pin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ser_on && $stable(pol_reg)) |=> (indicator_pin_one_out == (lit_reg[1] ~^ $past(pol_reg[1]))))
    else $error("pin level ignores polarity");

  drive_state_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!ser_on && $stable(tri_reg)) |=> (indicator_pin_zero_oe_n == (!lit_reg[0] && $past(tri_reg))))
    else $error("pin drive state wrong");

  link_any_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode0 == PSL_M_LINK && !link_up && !boot_on) |=> !lit_reg[0])
    else $error("link indicator lit without link");

  speed_one_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode1 == PSL_M_L1000 && link_speed != PSL_SPD_1000 && !boot_on) |=> !lit_reg[1])
    else $error("1000 indicator lit at other speed");

  speed_pair_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode0 == PSL_M_L100_1000 && link_speed == PSL_SPD_10 && !boot_on) |=> !lit_reg[0])
    else $error("pair indicator lit at 10");

  duplex_full_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode0 == PSL_M_DUPLEX && link_up && full_duplex && !boot_on) |=> lit_reg[0])
    else $error("full duplex not shown");

  aneg_fault_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (mode1 == PSL_M_ANFAULT && !boot_on) |=> (lit_reg[1] == $past(aneg_fault)))
    else $error("fault indicator mismatch");

  serial_data_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ser_on && $past(ser_on) && $past(ser_on, 2) && $rose(indicator_pin_one_out)) |->
      $stable(indicator_pin_zero_out))
    else $error("serial data moved at clock rise");

  bus_answer_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (req && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule
`default_nettype wire
